// File: rtl/bcsi_fifo.sv
// synchronous valid/ready fifo for received frame bytes
`timescale 1ns/1ps
module bcsi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // bcsi_fifo

// File: rtl/bcsi_pkg.sv
// package of constants and types for the bar code serial input block
package bcsi_pkg;
  // ==========================================================================
  // clock and line rates
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned BAUD_4800   = 4800;
  localparam int unsigned BAUD_9600   = 9600;
  localparam int unsigned BAUD_19200  = 19200;
  // ==========================================================================
  // configuration encodings
  localparam logic [1:0] RATE_4800    = 2'h0;
  localparam logic [1:0] RATE_9600    = 2'h1;
  localparam logic [1:0] RATE_19200   = 2'h2;
  localparam logic [1:0] PAR_NONE     = 2'h0;
  localparam logic [1:0] PAR_ODD      = 2'h1;
  localparam logic [1:0] PAR_EVEN     = 2'h2;
  localparam logic       DBITS_7      = 1'h0;
  localparam logic       DBITS_8      = 1'h1;
  localparam logic       STOP_1       = 1'h0;
  localparam logic       STOP_2       = 1'h1;
  localparam logic       MODE_MANUAL  = 1'h0;
  localparam logic       MODE_AUTO    = 1'h1;
  // defaults
  localparam logic [1:0] DEF_RATE     = RATE_9600;
  localparam logic [1:0] DEF_PARITY   = PAR_EVEN;
  localparam logic       DEF_DBITS    = DBITS_7;
  localparam logic       DEF_STOP     = STOP_2;
  localparam logic       DEF_MODE     = MODE_MANUAL;
  // ==========================================================================
  // frame format
  localparam logic [7:0] CH_START     = 8'h02;
  localparam logic [7:0] CH_END       = 8'h03;
  localparam logic [7:0] CH_MIN       = 8'h20;
  localparam logic [7:0] CH_MAX       = 8'h7f;
  localparam int unsigned MAX_LEN     = 40;
  localparam int unsigned FIFO_DEPTH  = 16;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_DATA  = 4'b0010,
    RX_STOP  = 4'b0100,
    RX_DONE  = 4'b1000
  } bcsi_rx_t;

  typedef enum logic [3:0] {
    FR_HUNT  = 4'b0001,
    FR_BODY  = 4'b0010,
    FR_SEND  = 4'b0100,
    FR_HOLD  = 4'b1000
  } bcsi_fr_t;

  // bit period in clocks, truncated, for the given clock figure
  function automatic logic [15:0] bcsi_div(input logic [1:0] rate, input int unsigned clk_hz);
    unique case (rate)
      RATE_4800:  bcsi_div = 16'(clk_hz / BAUD_4800);
      RATE_19200: bcsi_div = 16'(clk_hz / BAUD_19200);
      default:    bcsi_div = 16'(clk_hz / BAUD_9600);
    endcase
  endfunction
endpackage

// File: rtl/bcsi_rx.sv
// asynchronous serial receiver with selectable framing and rate
`timescale 1ns/1ps
module bcsi_rx
  import bcsi_pkg::*;
#(
  parameter int unsigned CLK_FREQ = CLK_HZ
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       rxd_sync,
  input  wire logic [1:0] cfg_rate,
  input  wire logic [1:0] cfg_parity,
  input  wire logic       cfg_dbits,
  input  wire logic       cfg_stop,
  output logic [7:0]      rx_byte_r,
  output logic            rx_stb_r,
  output logic            rx_err_r
);
  bcsi_rx_t    st_r;
  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic [1:0]  stop_r;
  logic [8:0]  sh_r;
  logic [15:0] div;
  logic [3:0]  nbits;
  logic        par_ok;

  assign div   = bcsi_div(cfg_rate, CLK_FREQ);
  // data bits plus optional parity bit
  assign nbits = (cfg_dbits == DBITS_8 ? 4'h8 : 4'h7) + ((cfg_parity == PAR_NONE) ? 4'h0 : 4'h1);

  always_comb begin
    par_ok = 1'b1;
    if (cfg_parity != PAR_NONE) begin
      par_ok = ((cfg_dbits == DBITS_8) ? ^sh_r[8:0] : ^sh_r[8:1]) ^ (cfg_parity == PAR_ODD);
      par_ok = !par_ok;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r      <= RX_IDLE;
      cnt_r     <= '0;
      bit_r     <= '0;
      stop_r    <= '0;
      sh_r      <= '0;
      rx_byte_r <= '0;
      rx_stb_r  <= 1'b0;
      rx_err_r  <= 1'b0;
    end else begin
      rx_stb_r <= 1'b0;
      unique case (st_r)
        RX_IDLE: begin
          cnt_r <= {1'b0, div[15:1]};
          if (!rxd_sync) st_r <= RX_DATA;
          bit_r <= '0;
          sh_r  <= '0;
        end
        RX_DATA: begin
          if (cnt_r == '0) begin
            cnt_r <= div - 16'h1;
            if (bit_r == 4'h0 && rxd_sync) begin
              st_r <= RX_IDLE;                 // false start bit
            end else if (bit_r == nbits) begin
              st_r   <= RX_STOP;
              stop_r <= (cfg_stop == STOP_2) ? 2'h2 : 2'h1;
              sh_r   <= {rxd_sync, sh_r[8:1]};
            end else begin
              bit_r <= bit_r + 4'h1;
              if (bit_r != 4'h0) sh_r <= {rxd_sync, sh_r[8:1]};
            end
          end else begin
            cnt_r <= cnt_r - 16'h1;
          end
        end
        RX_STOP: begin
          // stop bits sampled at their middles
          if (cnt_r == '0) begin
            cnt_r <= div - 16'h1;
            if (!rxd_sync) rx_err_r <= 1'b1;
            if (stop_r == 2'h1) st_r <= RX_DONE;
            stop_r <= stop_r - 2'h1;
          end else begin
            cnt_r <= cnt_r - 16'h1;
          end
        end
        RX_DONE: begin
          // align received bits to bit 0 according to width
          rx_byte_r <= (cfg_dbits == DBITS_8) ?
                       ((cfg_parity == PAR_NONE) ? sh_r[8:1] : sh_r[7:0]) :
                       ((cfg_parity == PAR_NONE) ? {1'b0, sh_r[8:2]} : {1'b0, sh_r[7:1]});
          rx_err_r  <= rx_err_r || !par_ok;
          rx_stb_r  <= 1'b1;
          st_r      <= RX_IDLE;
        end
        default: st_r <= RX_IDLE;
      endcase
      if (st_r == RX_IDLE) rx_err_r <= 1'b0;
    end
  end
endmodule // bcsi_rx

// File: rtl/bcsi_top.sv
// bar code serial input: receiver, frame checker, hold-off and string output
`timescale 1ns/1ps
module bcsi_top
  import bcsi_pkg::*;
#(
  parameter int unsigned CLK_FREQ = CLK_HZ
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       rxd_pin,
  input  wire logic       clear_to_send_pin,
  output logic            receive_permit_out,
  input  wire logic       cfg_port_barcode,
  input  wire logic [1:0] cfg_rate,
  input  wire logic [1:0] cfg_parity,
  input  wire logic       cfg_dbits,
  input  wire logic       cfg_stop,
  input  wire logic       cfg_mode,
  input  wire logic       host_reported,
  output logic [7:0]      str_data,
  output logic            str_valid,
  output logic            str_last,
  input  wire logic       str_ready,
  output logic            frame_drop,
  output logic            frame_held
);
  // ==========================================================================
  // pin synchronisers
  logic [1:0] rxd_s_r;
  logic [1:0] cts_s_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_s_r <= 2'b11;
      cts_s_r <= 2'b00;
    end else begin
      rxd_s_r <= {rxd_s_r[0], rxd_pin};
      cts_s_r <= {cts_s_r[0], clear_to_send_pin};
    end
  end

  // ==========================================================================
  // serial receiver
  logic [7:0] rx_byte;
  logic       rx_stb;
  logic       rx_err;
  logic       port_on;

  assign port_on = cfg_port_barcode;

  bcsi_rx #(
    .CLK_FREQ (CLK_FREQ)
  ) u_rx (
    .clk_sys    (clk_sys),
    .rst        (rst || !port_on),
    .rxd_sync   (rxd_s_r[1]),
    .cfg_rate   (cfg_rate),
    .cfg_parity (cfg_parity),
    .cfg_dbits  (cfg_dbits),
    .cfg_stop   (cfg_stop),
    .rx_byte_r  (rx_byte),
    .rx_stb_r   (rx_stb),
    .rx_err_r   (rx_err)
  );

  // ==========================================================================
  // frame parser into the fifo
  bcsi_fr_t   fr_r;
  logic [5:0] len_r;
  logic       bad_r;
  logic       f_in_valid;
  logic       f_in_ready;
  logic [7:0] f_out_data;
  logic       f_out_valid;
  logic       f_out_ready;
  logic       flush;
  logic       byte_ok;
  logic [5:0] out_left_r;
  logic       drop_r;
  logic       hold_r;
  logic       permit_r;
  logic       send_done;

  assign byte_ok    = !rx_err && rx_byte >= CH_MIN && rx_byte <= CH_MAX;
  assign f_in_valid = rx_stb && fr_r == FR_BODY && byte_ok && !bad_r
                      && len_r < 6'(MAX_LEN);
  // a bad frame or a start byte arriving in any state but send restarts the buffer
  assign flush      = !port_on || drop_r
                      || (rx_stb && rx_byte == CH_START && fr_r != FR_SEND);
  assign send_done  = fr_r == FR_SEND && out_left_r == 6'h0;

  always_ff @(posedge clk_sys) begin
    if (rst || !port_on) begin
      fr_r   <= FR_HUNT;
      len_r  <= '0;
      bad_r  <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      drop_r <= 1'b0;
      unique case (fr_r)
        FR_HUNT, FR_HOLD: begin
          if (rx_stb && rx_byte == CH_START && !rx_err) begin
            fr_r  <= FR_BODY;
            len_r <= '0;
            bad_r <= 1'b0;
          end
        end
        FR_BODY: begin
          if (rx_stb) begin
            if (rx_byte == CH_END && !rx_err) begin
              if (bad_r || len_r == 6'h0) begin
                fr_r   <= FR_HUNT;
                drop_r <= 1'b1;
              end else begin
                fr_r <= FR_SEND;
              end
            end else if (rx_byte == CH_START && !rx_err) begin
              len_r <= '0;                     // restart on a fresh start byte
              bad_r <= 1'b0;
            end else if (!byte_ok || len_r == 6'(MAX_LEN) || !f_in_ready) begin
              bad_r <= 1'b1;
            end else begin
              len_r <= len_r + 6'h1;
            end
          end
        end
        FR_SEND: begin
          if (send_done) fr_r <= (cfg_mode == MODE_AUTO) ? FR_HOLD : FR_HUNT;
        end
        default: fr_r <= FR_HUNT;
      endcase
    end
  end

  bcsi_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (flush),
    .in_data   (rx_byte),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // ==========================================================================
  // string output: released only once the whole frame passed its checks
  // limitation: frames beyond fifo depth are dropped, as nothing drains early
  logic str_fire;

  assign f_out_ready = fr_r == FR_SEND && (!str_valid || str_ready) && out_left_r != 6'h0;
  assign str_fire    = f_out_ready && f_out_valid;

  always_ff @(posedge clk_sys) begin
    if (rst || !port_on) begin
      str_data   <= '0;
      str_valid  <= 1'b0;
      str_last   <= 1'b0;
      out_left_r <= '0;
    end else begin
      if (fr_r == FR_BODY && rx_stb && rx_byte == CH_END && !rx_err && !bad_r) begin
        out_left_r <= len_r;
      end else if (str_fire) begin
        out_left_r <= out_left_r - 6'h1;
      end
      if (str_fire) begin
        str_data  <= f_out_data;
        str_valid <= 1'b1;
        str_last  <= out_left_r == 6'h1;
      end else if (str_ready) begin
        str_valid <= 1'b0;
        str_last  <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // handshake toward the reader
  // hold set when a frame is passed on in auto mode; host report clears it
  always_ff @(posedge clk_sys) begin
    if (rst || !port_on) begin
      hold_r <= 1'b0;
    end else if (send_done && cfg_mode == MODE_AUTO) begin
      hold_r <= 1'b1;
    end else if (host_reported || cfg_mode == MODE_MANUAL) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !port_on) begin
      permit_r <= 1'b0;
    end else begin
      // permit drops while a frame is in send, to give send path time
      permit_r <= !hold_r && fr_r != FR_SEND && !(send_done && cfg_mode == MODE_AUTO);
    end
  end

  assign receive_permit_out = permit_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_drop <= 1'b0;
      frame_held <= 1'b0;
    end else begin
      frame_drop <= drop_r;
      frame_held <= hold_r && cts_s_r[1];
    end
  end

  // ==========================================================================
  // checks
  property p_hold_blocks_permit;
    @(posedge clk_sys) disable iff (rst)
    hold_r |=> !receive_permit_out;
  endproperty
  a_hold_blocks_permit: assert property (p_hold_blocks_permit)
    else $error("permit high while holding");

  property p_auto_sets_hold;
    @(posedge clk_sys) disable iff (rst || !port_on)
    (send_done && cfg_mode == MODE_AUTO) |=> hold_r ##1 !receive_permit_out;
  endproperty
  a_auto_sets_hold: assert property (p_auto_sets_hold)
    else $error("auto frame did not hold");

  property p_manual_permit;
    @(posedge clk_sys) disable iff (rst || !port_on)
    (cfg_mode == MODE_MANUAL && fr_r == FR_HUNT) [*2] |=> receive_permit_out;
  endproperty
  a_manual_permit: assert property (p_manual_permit)
    else $error("manual mode permit low");

  property p_range;
    @(posedge clk_sys) disable iff (rst)
    str_valid |-> str_data >= CH_MIN && str_data <= CH_MAX;
  endproperty
  a_range: assert property (p_range)
    else $error("out of range byte stored");

  property p_len;
    @(posedge clk_sys) disable iff (rst)
    len_r <= 6'(MAX_LEN);
  endproperty
  a_len: assert property (p_len)
    else $error("payload length over limit");

  property p_drop_no_out;
    @(posedge clk_sys) disable iff (rst)
    drop_r |-> !f_out_ready;
  endproperty
  a_drop_no_out: assert property (p_drop_no_out)
    else $error("dropped frame passed on");

  property p_port_off;
    @(posedge clk_sys) disable iff (rst)
    !port_on |=> !receive_permit_out && !str_valid;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("port active while not selected");

  property p_send_after_end;
    @(posedge clk_sys) disable iff (rst || !port_on)
    (fr_r == FR_BODY && rx_stb && rx_byte == CH_END && !rx_err && !bad_r && len_r != 0)
      |=> fr_r == FR_SEND;
  endproperty
  a_send_after_end: assert property (p_send_after_end)
    else $error("end byte did not close frame");

  property p_drop_pulse;
    @(posedge clk_sys) disable iff (rst)
    drop_r |=> frame_drop ##1 !frame_drop;
  endproperty
  a_drop_pulse: assert property (p_drop_pulse)
    else $error("drop not flagged as one pulse");

  property p_report_clears_hold;
    @(posedge clk_sys) disable iff (rst || !port_on)
    (host_reported && !send_done) |=> !hold_r;
  endproperty
  a_report_clears_hold: assert property (p_report_clears_hold)
    else $error("host report did not release hold");

  property p_manual_no_hold;
    @(posedge clk_sys) disable iff (rst || !port_on)
    (cfg_mode == MODE_MANUAL) |=> !hold_r;
  endproperty
  a_manual_no_hold: assert property (p_manual_no_hold)
    else $error("hold active in manual mode");
endmodule // bcsi_top

// File: verification/bcsi_reader.sv
// bar code reader model: asynchronous serial sender that honours the permit line
`timescale 1ns/1ps
module bcsi_reader (
  input  wire logic clk_sys,
  input  wire logic permit_in,
  output logic      rxd_pin,
  output logic      cts_out
);
  int timeouts = 0;
  // ==========================================================================
  // line idles at mark level; reader always ready for the device
  initial begin
    rxd_pin = 1'b1;
    cts_out = 1'b1;
  end
  task automatic send_bit(input logic b, input int div);
    rxd_pin <= b;
    repeat (div) @(posedge clk_sys);
  endtask
  // ==========================================================================
  task automatic send_byte(input logic [7:0] b, input int nd, input int par, input int ns,
                           input int div, input bit obey);
    int   i;
    logic p;
    i = 0;
    while (obey && permit_in !== 1'b1 && i < 20000) begin
      @(posedge clk_sys);
      i++;
    end
    if (i >= 20000) timeouts++;
    p = ^(b & ((nd == 7) ? 8'h7f : 8'hff));
    send_bit(1'b0, div);
    for (int k = 0; k < nd; k++) send_bit(b[k], div);
    if (par == 2) send_bit(p, div);
    if (par == 1) send_bit(~p, div);
    repeat (ns) send_bit(1'b1, div);
  endtask
  // caller supplies the delimiters, so malformed frames can be sent too
  task automatic send_frame(input logic [7:0] q[$], input int nd, input int par,
                            input int ns, input int div, input bit obey);
    foreach (q[j]) send_byte(q[j], nd, par, ns, div, obey);
  endtask
endmodule // bcsi_reader

// File: verification/bcsi_top_tb.sv
// self-checking bench for the bar code serial input block
`timescale 1ns/1ps
module bcsi_top_tb
  import bcsi_pkg::*;
();
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       rxd_pin;
  logic       cts;
  logic       permit;
  logic       cfg_port_barcode = 1'b1;
  logic [1:0] cfg_rate = DEF_RATE;
  logic [1:0] cfg_parity = DEF_PARITY;
  logic       cfg_dbits = DEF_DBITS;
  logic       cfg_stop = DEF_STOP;
  logic       cfg_mode = DEF_MODE;
  logic       host_reported = 1'b0;
  logic [7:0] str_data;
  logic       str_valid;
  logic       str_last;
  logic       str_ready = 1'b0;
  logic       frame_drop;
  logic       frame_held;
  int         errors = 0;
  int         num_checks = 0;
  int         drops = 0;
  int         lasts = 0;
  // scaled clock figure for the divisors keeps every serial frame short
  localparam int unsigned SIM_HZ = 192000;
  int         nd, par, ns, div;
  logic [7:0] got[$];
  logic [7:0] tx[$];
  logic       last_seen;

  always #20 clk_sys = ~clk_sys;
  // far side stalls every other cycle
  always @(posedge clk_sys) str_ready <= ~str_ready;

  bcsi_top #(.CLK_FREQ(SIM_HZ)) dut (.clk_sys(clk_sys), .rst(rst), .rxd_pin(rxd_pin),
    .clear_to_send_pin(cts), .receive_permit_out(permit), .cfg_port_barcode(cfg_port_barcode),
    .cfg_rate(cfg_rate), .cfg_parity(cfg_parity), .cfg_dbits(cfg_dbits), .cfg_stop(cfg_stop),
    .cfg_mode(cfg_mode), .host_reported(host_reported), .str_data(str_data),
    .str_valid(str_valid), .str_last(str_last), .str_ready(str_ready),
    .frame_drop(frame_drop), .frame_held(frame_held));
  bcsi_reader rdr (.clk_sys(clk_sys), .permit_in(permit), .rxd_pin(rxd_pin), .cts_out(cts));

  // ==========================================================================
  // output monitor
  always @(posedge clk_sys) begin
    if (str_valid === 1'b1 && str_ready === 1'b1) begin
      got.push_back(str_data);
      last_seen = str_last;
      if (str_last === 1'b1) lasts++;
    end
    if (frame_drop === 1'b1) drops++;
  end
  // ==========================================================================
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_flag(input logic e, input logic g);
    chk_byte({7'h0, e}, {7'h0, g});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic setcfg(input logic [1:0] r, input logic [1:0] p, input logic d,
                        input logic s, input logic m);
    @(posedge clk_sys);
    cfg_rate <= r;
    cfg_parity <= p;
    cfg_dbits <= d;
    cfg_stop <= s;
    cfg_mode <= m;
    nd = (d == DBITS_8) ? 8 : 7;
    par = int'(p);
    ns = (s == STOP_2) ? 2 : 1;
    div = SIM_HZ / ((r == RATE_4800) ? 4800 : (r == RATE_19200) ? 19200 : 9600);
  endtask
  // send one byte string, then compare the string output and drop count
  task automatic frame(input logic [7:0] ex[$], input int edrop, input bit obey,
                       input string name);
    int n;
    got.delete();
    drops = 0;
    lasts = 0;
    last_seen = 1'b0;
    rdr.send_frame(tx, nd, par, ns, div, obey);
    n = 0;
    while (n < 400 && (got.size() < ex.size() || drops < edrop)) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      errors++;
      report_and_stop();
    end
    repeat (20) @(posedge clk_sys);
    chk_byte(8'(ex.size()), 8'(got.size()));
    foreach (ex[i]) chk_byte(ex[i], got[i]);
    if (ex.size() > 0) chk_flag(1'b1, last_seen);
    chk_byte((ex.size() > 0) ? 8'h01 : 8'h00, 8'(lasts));
    chk_byte(8'(edrop), 8'(drops));
    $display("test %s done", name);
  endtask
  task automatic pulse_report;
    @(posedge clk_sys);
    host_reported <= 1'b1;
    @(posedge clk_sys);
    host_reported <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // ==========================================================================
  initial begin
    setcfg(DEF_RATE, DEF_PARITY, DEF_DBITS, DEF_STOP, DEF_MODE);
    repeat (3) @(posedge clk_sys);
    chk_flag(1'b0, permit);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_flag(1'b1, permit);
    // noise before the start byte is ignored; defaults 7E2 at 9600
    tx = '{8'h31, 8'h02, 8'h41, 8'h7a, 8'h03};
    frame('{8'h41, 8'h7a}, 0, 1'b1, "defaults");
    setcfg(RATE_4800, PAR_ODD, DBITS_8, STOP_1, MODE_MANUAL);
    tx = '{8'h02, 8'h7f, 8'h03};
    frame('{8'h7f}, 0, 1'b1, "rate_4800_odd");
    setcfg(RATE_19200, PAR_NONE, DBITS_8, STOP_1, MODE_MANUAL);
    tx = '{8'h02, 8'h20, 8'h03};
    frame('{8'h20}, 0, 1'b1, "rate_19200_none");
    tx = '{8'h02, 8'h41, 8'h1f, 8'h03};
    frame('{}, 1, 1'b1, "below_range");
    tx = '{8'h02, 8'h80, 8'h03};
    frame('{}, 1, 1'b1, "above_range");
    tx = '{8'h02};
    repeat (41) tx.push_back(8'h30);
    tx.push_back(8'h03);
    frame('{}, 1, 1'b1, "too_long");
    setcfg(RATE_19200, PAR_EVEN, DBITS_8, STOP_2, MODE_AUTO);
    tx = '{8'h02, 8'h43, 8'h03};
    frame('{8'h43}, 0, 1'b1, "auto_frame");
    chk_flag(1'b0, permit);
    chk_flag(1'b1, frame_held);
    // looped handshake: reader ignores the permit, data is replaced
    tx = '{8'h02, 8'h44, 8'h03};
    frame('{8'h44}, 0, 1'b0, "looped_first");
    tx = '{8'h02, 8'h45, 8'h03};
    frame('{8'h45}, 0, 1'b0, "looped_second");
    chk_flag(1'b0, permit);
    pulse_report();
    chk_flag(1'b1, permit);
    chk_flag(1'b0, frame_held);
    cfg_port_barcode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_flag(1'b0, permit);
    tx = '{8'h02, 8'h46, 8'h03};
    frame('{}, 0, 1'b0, "port_off");
    cfg_port_barcode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk_flag(1'b1, permit);
    tx = '{8'h02, 8'h47, 8'h03};
    frame('{8'h47}, 0, 1'b1, "port_back");
    chk_byte(8'h00, 8'(rdr.timeouts));
    report_and_stop();
  end
endmodule // bcsi_top_tb
